// [rtl/fisw_pkg.sv]
// Package with constants and types for the fast interrupt context swap unit.
// Operation
// - Mode bits 4..2 pick the fast level
// - Mode bit 1 enables fast service while mode bit 0 (global enable) is also set
// - Fast entry swaps pointer and program counter
// - Fast entry copies flags into hidden shadow
// - Fast entry sets fast-active flag bit
// - Return with fast-active set swaps back
// - Fast return restores flags from shadow
// - Fast return clears fast-active bit itself
// - Works with hardware- or software-cleared pending bits
// - Global enable gates fast service too
// - Pointer is register pair DAH high, DBH low
// - Fast entry 6 cycles, normal entry 16
// - Flags bit 1 blocks interrupts, selects return
package fisw_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] PTR_HI_IDX = 8'hda;
  localparam logic [7:0] PTR_LO_IDX = 8'hdb;
  localparam logic [7:0] FLAGS_IDX = 8'hd5;
  localparam logic [7:0] REQ_IDX = 8'hdc;
  localparam logic [7:0] MASK_IDX = 8'hdd;
  localparam logic [7:0] MODE_IDX = 8'hdf;

  // Field positions.
  localparam int unsigned FIS_BIT = 1;

  // Reset values.
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;

  // Entry lengths in core clock cycles.
  localparam logic [4:0] FAST_ENTRY_CYC = 5'h06;
  localparam logic [4:0] NORM_ENTRY_CYC = 5'h10;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] spare;
    logic [2:0] fast_level;
    logic fast_en;
    logic global_en;
  } fisw_mode_t;

  localparam fisw_mode_t MODE_RST = '{3'h0, 3'h0, 1'b0, 1'b0};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FAST = 2'b01,
    ST_NORM = 2'b10
  } fisw_state_t;

  // Program counter load toward the core.
  typedef struct packed {
    logic load;
    logic [15:0] value;
  } fisw_pc_cmd_t;

endpackage : fisw_pkg

// [rtl/fisw_top.sv]
// Fast interrupt context swap unit with an AXI4-Lite register slave.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module fisw_top
  import fisw_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side inputs
  input wire logic [7:0] request_level_number,
  input wire logic insn_boundary,
  input wire logic global_irq_on_op,
  input wire logic global_irq_off_op,
  input wire logic service_return_op,
  input wire logic [15:0] pc_current,
  input wire logic core_flags_we,
  input wire logic [7:0] core_flags_wd,
  // Core side outputs
  output fisw_pc_cmd_t pc_cmd,
  output logic [7:0] status_flags,
  output logic irq_ack,
  output logic [2:0] irq_ack_level,
  output logic vector_entry,
  output logic normal_return
);

  // Lowest level number wins among unmasked requests.
  function automatic logic [2:0] pick_level(input logic [7:0] req);
    logic [2:0] lvl;
    lvl = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (req[i]) begin
        lvl = 3'(i);
      end
    end
    return lvl;
  endfunction : pick_level

  function automatic logic is_mapped(input logic [7:0] idx);
    return (idx == PTR_HI_IDX) || (idx == PTR_LO_IDX) ||
           (idx == FLAGS_IDX) || (idx == REQ_IDX) ||
           (idx == MASK_IDX) || (idx == MODE_IDX);
  endfunction : is_mapped

  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = (a[1:0] == 2'h0) && ((a >> 10) == '0);
    return ok ? a[9:2] : 8'h00;
  endfunction : word_index

  // Bus state.
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0] wr_idx_q, wr_idx_d;
  logic [7:0] wr_byte_q, wr_byte_d;
  logic wr_lane_q, wr_lane_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_fire;

  // Unit state.
  fisw_state_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [2:0] lvl_q, lvl_d;
  fisw_mode_t mode_q, mode_d;
  logic [15:0] ptr_q, ptr_d;
  logic [7:0] flags_q, flags_d, shadow_q, shadow_d, mask_q, mask_d;
  fisw_pc_cmd_t pc_cmd_q, pc_cmd_d;
  logic ack_q, ack_d, vec_q, vec_d, nret_q, nret_d;
  logic [7:0] live_req;
  logic take;

  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign live_req = request_level_number & mask_q;
  // A set fast-active bit blocks every further entry.
  assign take = insn_boundary && mode_q.global_en && !flags_q[FIS_BIT] &&
                (live_req != 8'h00) && (state_q == ST_IDLE) &&
                !service_return_op;

  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    wr_idx_d = wr_idx_q;
    wr_byte_d = wr_byte_q;
    wr_lane_d = wr_lane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && awready_q) begin
      aw_got_d = 1'b1;
      wr_idx_d = word_index(s_axi_awaddr);
    end
    if (s_axi_wvalid && wready_q) begin
      w_got_d = 1'b1;
      wr_byte_d = s_axi_wdata[7:0];
      wr_lane_d = s_axi_wstrb[0];
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = is_mapped(wr_idx_q) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = is_mapped(word_index(s_axi_araddr)) ? RESP_OKAY :
                RESP_SLVERR;
      case (word_index(s_axi_araddr))
        PTR_HI_IDX: rdata_d = {24'h0, ptr_q[15:8]};
        PTR_LO_IDX: rdata_d = {24'h0, ptr_q[7:0]};
        FLAGS_IDX: rdata_d = {24'h0, flags_q};
        REQ_IDX: rdata_d = {24'h0, request_level_number};
        MASK_IDX: rdata_d = {24'h0, mask_q};
        MODE_IDX: rdata_d = {24'h0, mode_q};
        default: rdata_d = 32'h0;
      endcase
    end
    awready_d = !aw_got_d && !bvalid_d;
    wready_d = !w_got_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    mode_d = mode_q;
    ptr_d = ptr_q;
    flags_d = flags_q;
    shadow_d = shadow_q;
    mask_d = mask_q;
    pc_cmd_d = '{1'b0, pc_cmd_q.value};
    ack_d = 1'b0;
    vec_d = 1'b0;
    nret_d = 1'b0;
    if (core_flags_we) begin
      flags_d = core_flags_wd;
    end
    // Software writes land first so that hardware events below win.
    if (wr_fire && wr_lane_q) begin
      case (wr_idx_q)
        PTR_HI_IDX: ptr_d[15:8] = wr_byte_q;
        PTR_LO_IDX: ptr_d[7:0] = wr_byte_q;
        FLAGS_IDX: flags_d = wr_byte_q;
        MASK_IDX: mask_d = wr_byte_q;
        MODE_IDX: mode_d = fisw_mode_t'(wr_byte_q);
        default: mode_d = mode_d;
      endcase
    end
    if (global_irq_on_op) begin
      mode_d.global_en = 1'b1;
    end
    if (global_irq_off_op) begin
      mode_d.global_en = 1'b0;
    end
    case (state_q)
      ST_IDLE: begin
        if (service_return_op && flags_q[FIS_BIT]) begin
          pc_cmd_d = '{1'b1, ptr_q};
          ptr_d = pc_current;
          flags_d = shadow_q;
          flags_d[FIS_BIT] = 1'b0;
        end else if (service_return_op) begin
          mode_d.global_en = 1'b1;
          nret_d = 1'b1;
        end else if (take) begin
          // The acknowledge lets hardware-cleared sources drop their
          // pending bit; software-cleared ones simply ignore it.
          ack_d = 1'b1;
          lvl_d = pick_level(live_req);
          if (mode_q.fast_en &&
              pick_level(live_req) == mode_q.fast_level) begin
            state_d = ST_FAST;
            cnt_d = FAST_ENTRY_CYC - 5'h01;
          end else begin
            mode_d.global_en = 1'b0;
            state_d = ST_NORM;
            cnt_d = NORM_ENTRY_CYC - 5'h01;
          end
        end
      end
      ST_FAST: begin
        cnt_d = cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          state_d = ST_IDLE;
          pc_cmd_d = '{1'b1, ptr_q};
          ptr_d = pc_current;
          shadow_d = flags_q;
          flags_d[FIS_BIT] = 1'b1;
        end
      end
      ST_NORM: begin
        cnt_d = cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          state_d = ST_IDLE;
          vec_d = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      wr_idx_q <= 8'h00;
      wr_byte_q <= 8'h00;
      wr_lane_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      wr_idx_q <= wr_idx_d;
      wr_byte_q <= wr_byte_d;
      wr_lane_q <= wr_lane_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      lvl_q <= 3'h0;
      mode_q <= MODE_RST;
      ptr_q <= PTR_RST;
      flags_q <= FLAGS_RST;
      shadow_q <= FLAGS_RST;
      mask_q <= MASK_RST;
      pc_cmd_q <= '{1'b0, 16'h0000};
      ack_q <= 1'b0;
      vec_q <= 1'b0;
      nret_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
      mode_q <= mode_d;
      ptr_q <= ptr_d;
      flags_q <= flags_d;
      shadow_q <= shadow_d;
      mask_q <= mask_d;
      pc_cmd_q <= pc_cmd_d;
      ack_q <= ack_d;
      vec_q <= vec_d;
      nret_q <= nret_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign pc_cmd = pc_cmd_q;
  assign status_flags = flags_q;
  assign irq_ack = ack_q;
  assign irq_ack_level = lvl_q;
  assign vector_entry = vec_q;
  assign normal_return = nret_q;

endmodule : fisw_top

// [sim/fisw_checker.sv]
// Assertion checker for the fast interrupt swap unit.
`timescale 1ns/1ps
module fisw_checker
  import fisw_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Core side
  input wire logic [7:0] request_level_number,
  input wire logic global_irq_on_op,
  input wire logic global_irq_off_op,
  input wire logic service_return_op,
  input wire fisw_pc_cmd_t pc_cmd,
  input wire logic [7:0] status_flags,
  input wire logic irq_ack,
  input wire logic [2:0] irq_ack_level,
  input wire logic vector_entry,
  input wire logic normal_return
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [7:0] req_q;
  logic fast_service_active;
  assign fast_service_active = status_flags[FIS_BIT];
  // The acknowledge lags the request it answers by one edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_q <= 8'h00;
    end else begin
      req_q <= request_level_number;
    end
  end
  a_entry_len: assert property (irq_ack |->
    (##5 (pc_cmd.load && fast_service_active)) or (##15 vector_entry))
    else $error("entry length wrong");
  a_fis_load: assert property ($rose(fast_service_active) |-> pc_cmd.load)
    else $error("fast flag set without swap");
  a_load_cause: assert property (pc_cmd.load |->
    $past(service_return_op) || $past(irq_ack, 5))
    else $error("program counter load without cause");
  a_fis_block: assert property (fast_service_active && $past(fast_service_active) |-> !irq_ack)
    else $error("entry taken while fast flag set");
  a_gate_off: assert property (global_irq_off_op ##1
    !global_irq_on_op |=> !irq_ack)
    else $error("entry taken while disabled");
  a_fast_ret: assert property (service_return_op && fast_service_active |=>
    pc_cmd.load && !fast_service_active)
    else $error("fast return not performed");
  a_norm_ret: assert property (normal_return |->
    $past(service_return_op) && !$past(fast_service_active))
    else $error("stack return while fast flag set");
  a_ack_level: assert property (irq_ack |-> req_q[irq_ack_level])
    else $error("acknowledged level not requesting");
  a_vec_plain: assert property (vector_entry |-> !fast_service_active && !pc_cmd.load)
    else $error("vectored entry with fast flag");
endmodule : fisw_checker

bind fisw_top fisw_checker fisw_checker_inst (.*);

// [sim/fisw_core_model.sv]
// Core model that follows program counter loads from the unit.
`timescale 1ns/1ps
module fisw_core_model
  import fisw_pkg::*;
#(
  parameter logic [15:0] PC_START = 16'h0000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Unit side
  input wire fisw_pc_cmd_t pc_cmd,
  output logic [15:0] pc_current,
  output logic insn_boundary,
  output logic service_return_op,
  // Bench command
  input wire logic ret_req,
  input wire logic stall_req
);
  // The program counter stands still so every swap value is predictable.
  // A stall keeps the core inside one instruction, so no entry may start.
  assign insn_boundary = !stall_req;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pc_current <= PC_START;
      service_return_op <= 1'b0;
    end else begin
      service_return_op <= ret_req;
      if (pc_cmd.load) begin
        pc_current <= pc_cmd.value;
      end
    end
  end
endmodule : fisw_core_model

// [sim/testbench.sv]
// Self-checking bench for the fast interrupt swap unit.
`timescale 1ns/1ps
module testbench
  import fisw_pkg::*;
();
  localparam logic [15:0] PC0 = 16'h0500;
  logic clk_sys, rst, ret_req, insn_boundary, service_return_op, stall_req;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, core_flags_we, irq_ack;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [7:0] request_level_number, core_flags_wd, status_flags;
  logic global_irq_on_op, global_irq_off_op, vector_entry, normal_return;
  logic [15:0] pc_current;
  logic [2:0] irq_ack_level;
  fisw_pc_cmd_t pc_cmd;
  int bad_count, check_count, acks, a0;

  fisw_top fisw_top_inst (.*);
  fisw_core_model #(.PC_START(PC0)) fisw_core_model_inst (.*);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(negedge clk_sys) if (irq_ack === 1'b1) acks++;

  task automatic chk(input string nm, input logic [31:0] g,
                     input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Each channel is released at the edge that takes it.
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic aw_hit, w_hit, aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge clk_sys);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      @(posedge clk_sys);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
      aw_done = aw_done || aw_hit;
      w_done = w_done || w_hit;
    end while (!(aw_done && w_done));
    @(negedge clk_sys iff s_axi_bvalid);
    br = s_axi_bresp;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    @(posedge clk_sys);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    @(negedge clk_sys iff s_axi_arready);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    @(negedge clk_sys iff s_axi_rvalid);
    rr = s_axi_rresp;
    chk("register", s_axi_rdata, {24'h0, e});
    @(posedge clk_sys);
  endtask : rd

  // Clearing the request at the acknowledge mimics a hardware-cleared source.
  task automatic irq(input logic [2:0] l, input logic f, input logic c);
    int n;
    n = 0;
    @(posedge clk_sys);
    request_level_number <= 8'h01 << l;
    @(negedge clk_sys iff irq_ack);
    chk("level", irq_ack_level, l);
    @(posedge clk_sys);
    if (c) request_level_number <= 8'h00;
    do begin
      @(negedge clk_sys);
      n++;
    end while (!(pc_cmd.load || vector_entry));
    chk("fast entry", pc_cmd.load, f);
    chk("entry cycles", n, f ? 5 : 15);
    @(posedge clk_sys);
    request_level_number <= 8'h00;
  endtask : irq

  task automatic ret(input logic f);
    @(posedge clk_sys);
    ret_req <= 1'b1;
    @(posedge clk_sys);
    ret_req <= 1'b0;
    @(negedge clk_sys iff (pc_cmd.load || normal_return));
    chk("fast return", pc_cmd.load, f);
  endtask : ret

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end

  initial begin
    {bad_count, check_count, acks} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ret_req, stall_req} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {global_irq_on_op, global_irq_off_op, core_flags_we} = '0;
    {request_level_number, core_flags_wd} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    rst = 1'b1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(FLAGS_IDX, FLAGS_RST);
    rd(PTR_HI_IDX, PTR_RST[15:8]);
    rd(MODE_IDX, MODE_RST);
    rd(8'h10, 8'h00);
    chk("read response", rr, RESP_SLVERR);
    wr(PTR_HI_IDX, 8'h12);
    wr(PTR_LO_IDX, 8'h34);
    rd(PTR_LO_IDX, 8'h34);
    wr(MASK_IDX, 8'hff);
    chk("write response", br, RESP_OKAY);
    wr(8'h10, 8'h00);
    chk("write response", br, RESP_SLVERR);
    wr(FLAGS_IDX, 8'ha1);
    wr(MODE_IDX, 8'h0f);
    irq(3'h3, 1'b1, 1'b1);
    chk("pc", pc_cmd.value, 16'h1234);
    chk("flags", status_flags, 8'ha3);
    rd(PTR_HI_IDX, PC0[15:8]);
    a0 = acks;
    request_level_number <= 8'h08;
    repeat (8) @(posedge clk_sys);
    chk("blocked acks", acks, a0);
    request_level_number <= 8'h00;
    core_flags_wd <= 8'h52;
    core_flags_we <= 1'b1;
    @(posedge clk_sys);
    core_flags_we <= 1'b0;
    @(negedge clk_sys);
    chk("core flags", status_flags, 8'h52);
    ret(1'b1);
    chk("pc", pc_cmd.value, PC0);
    chk("flags", status_flags, 8'ha1);
    wr(PTR_HI_IDX, 8'h12);
    irq(3'h3, 1'b1, 1'b0);
    ret(1'b1);
    chk("flags", status_flags, 8'ha1);
    irq(3'h5, 1'b0, 1'b1);
    ret(1'b0);
    @(posedge clk_sys);
    global_irq_off_op <= 1'b1;
    @(posedge clk_sys);
    global_irq_off_op <= 1'b0;
    a0 = acks;
    request_level_number <= 8'h08;
    repeat (8) @(posedge clk_sys);
    chk("disabled acks", acks, a0);
    stall_req <= 1'b1;
    global_irq_on_op <= 1'b1;
    @(posedge clk_sys);
    global_irq_on_op <= 1'b0;
    a0 = acks;
    repeat (8) @(posedge clk_sys);
    chk("stalled acks", acks, a0);
    stall_req <= 1'b0;
    request_level_number <= 8'h00;
    irq(3'h3, 1'b1, 1'b1);
    ret(1'b1);
    wr(MODE_IDX, 8'h0d);
    irq(3'h3, 1'b0, 1'b1);
    ret(1'b0);
    print_verdict();
  end
endmodule : testbench
